/* File: oar_remap.sv */
/*
 * opaque memory window and non-transparent remap window registers with
 * the request decoder that uses them.
 * assumes a register master on the same clock (one-cycle strobes, read data
 * the cycle after) and a request source on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "oar_defines.svh"

module oar_remap
    import oar_pkg::*;
(
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    // register port
    input  wire logic [`OAR_REG_AW-1:0] i_addr,
    input  wire logic [31:0]            i_wr_data,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [31:0]            o_rd_data,
    // decode request and answer
    input  wire oar_req_s               i_req,
    output var  oar_rsp_s               o_rsp,
    // window enables for the rest of the bridge
    output logic                        o_opaque_range_enable,
    output logic                        o_remap_enable
);

    // register fields
    logic [31:0] opaque_base_high_field_reg;
    logic [31:0] opaque_limit_high_field_reg;
    logic [11:0] opaque_base_low_field_reg;
    logic [11:0] opaque_limit_low_field_reg;
    logic        opaque_range_enable_reg;
    logic        remap_enable_reg;
    logic [11:0] pri_base_low_reg;
    logic [31:0] pri_base_high_reg;
    logic [11:0] sec_base_low_reg;
    logic [31:0] sec_base_high_reg;
    logic [11:0] sec_limit_low_reg;
    logic [31:0] sec_limit_high_reg;

    // hit counters and read-back
    logic [15:0] opq_cnt_reg;
    logic [15:0] rmp_cnt_reg;
    logic        status_clear;
    logic [31:0] rd_mux;
    oar_rsp_s    rsp_next;

    // window boundaries and decode
    oar_addr_t   opq_base;
    oar_addr_t   opq_limit;
    oar_addr_t   pri_base;
    oar_addr_t   sec_base;
    oar_addr_t   sec_limit;
    oar_addr_t   rmp_limit;
    oar_addr_t   req_offset;

    // hit flags
    logic        opq_in_span;
    logic        rmp_in_span;
    logic        rmp_span_ok;
    logic        opq_hit;
    logic        rmp_hit;

    // write strobe aimed at one register offset
    function automatic logic wr_at(input logic [`OAR_REG_AW-1:0] ofs);
        wr_at = i_wr && (i_addr == ofs);
    endfunction

    // opaque upper halves
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            opaque_base_high_field_reg <= `OAR_RST_WORD;
        end else if (wr_at(`OAR_OFS_OPQ_BHI)) begin
            opaque_base_high_field_reg <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            opaque_limit_high_field_reg <= `OAR_RST_WORD;
        end else if (wr_at(`OAR_OFS_OPQ_LHI)) begin
            opaque_limit_high_field_reg <= i_wr_data;
        end
    end

    // opaque lower base and limit
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            opaque_base_low_field_reg <= `OAR_RST_FIELD;
        end else if (wr_at(`OAR_OFS_OPQ_LOW)) begin
            opaque_base_low_field_reg <= i_wr_data[`OAR_LB_MSB:`OAR_LB_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            opaque_limit_low_field_reg <= `OAR_RST_FIELD;
        end else if (wr_at(`OAR_OFS_OPQ_LOW)) begin
            opaque_limit_low_field_reg <= i_wr_data[`OAR_LO_MSB:`OAR_LO_LSB];
        end
    end

    // opaque enable
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            opaque_range_enable_reg <= `OAR_RST_BIT;
        end else if (wr_at(`OAR_OFS_OPQ_CTRL)) begin
            opaque_range_enable_reg <= i_wr_data[`OAR_OPQ_EN_BIT];
        end
    end

    // remap control and primary base low
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            remap_enable_reg <= `OAR_RST_BIT;
        end else if (wr_at(`OAR_OFS_RMP_CTRL)) begin
            remap_enable_reg <= i_wr_data[`OAR_RMP_EN_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pri_base_low_reg <= `OAR_RST_FIELD;
        end else if (wr_at(`OAR_OFS_RMP_CTRL)) begin
            pri_base_low_reg <= i_wr_data[`OAR_LO_MSB:`OAR_LO_LSB];
        end
    end

    // primary base high
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pri_base_high_reg <= `OAR_RST_WORD;
        end else if (wr_at(`OAR_OFS_PRI_BHI)) begin
            pri_base_high_reg <= i_wr_data;
        end
    end

    // secondary base
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sec_base_low_reg <= `OAR_RST_FIELD;
        end else if (wr_at(`OAR_OFS_SEC_BLO)) begin
            sec_base_low_reg <= i_wr_data[`OAR_LO_MSB:`OAR_LO_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sec_base_high_reg <= `OAR_RST_WORD;
        end else if (wr_at(`OAR_OFS_SEC_BHI)) begin
            sec_base_high_reg <= i_wr_data;
        end
    end

    // secondary limit
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sec_limit_low_reg <= `OAR_RST_FIELD;
        end else if (wr_at(`OAR_OFS_SEC_LLO)) begin
            sec_limit_low_reg <= i_wr_data[`OAR_LO_MSB:`OAR_LO_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sec_limit_high_reg <= `OAR_RST_WORD;
        end else if (wr_at(`OAR_OFS_SEC_LHI)) begin
            sec_limit_high_reg <= i_wr_data;
        end
    end

    // read-back, reserved bits zero, unmapped offsets zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_addr)
            `OAR_OFS_OPQ_CTRL: begin
                rd_mux[`OAR_OPQ_EN_BIT] = opaque_range_enable_reg;
            end
            `OAR_OFS_OPQ_LOW: begin
                rd_mux[`OAR_LO_MSB:`OAR_LO_LSB]     = opaque_limit_low_field_reg;
                rd_mux[`OAR_LL64_MSB:`OAR_LL64_LSB] = `OAR_ADDR64_CODE;
                rd_mux[`OAR_LB_MSB:`OAR_LB_LSB]     = opaque_base_low_field_reg;
                rd_mux[`OAR_LB64_MSB:`OAR_LB64_LSB] = `OAR_ADDR64_CODE;
            end
            `OAR_OFS_OPQ_BHI: begin
                rd_mux = opaque_base_high_field_reg;
            end
            `OAR_OFS_OPQ_LHI: begin
                rd_mux = opaque_limit_high_field_reg;
            end
            `OAR_OFS_RMP_CTRL: begin
                rd_mux[`OAR_LO_MSB:`OAR_LO_LSB] = pri_base_low_reg;
                rd_mux[`OAR_RMP_EN_BIT]         = remap_enable_reg;
            end
            `OAR_OFS_PRI_BHI: begin
                rd_mux = pri_base_high_reg;
            end
            `OAR_OFS_SEC_BLO: begin
                rd_mux[`OAR_LO_MSB:`OAR_LO_LSB] = sec_base_low_reg;
            end
            `OAR_OFS_SEC_BHI: begin
                rd_mux = sec_base_high_reg;
            end
            `OAR_OFS_SEC_LLO: begin
                rd_mux[`OAR_LO_MSB:`OAR_LO_LSB] = sec_limit_low_reg;
            end
            `OAR_OFS_SEC_LHI: begin
                rd_mux = sec_limit_high_reg;
            end
            `OAR_OFS_STATUS: begin
                rd_mux = {rmp_cnt_reg, opq_cnt_reg};
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rd_data <= `OAR_RST_WORD;
        end else if (i_rd) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= `OAR_RST_WORD;
        end
    end

    // window boundaries
    always_comb begin
        opq_base    = oar_base64(opaque_base_high_field_reg, opaque_base_low_field_reg);
        opq_limit   = oar_limit64(opaque_limit_high_field_reg, opaque_limit_low_field_reg);
        pri_base    = oar_base64(pri_base_high_reg, pri_base_low_reg);
        sec_base    = oar_base64(sec_base_high_reg, sec_base_low_reg);
        sec_limit   = oar_limit64(sec_limit_high_reg, sec_limit_low_reg);
        // an inverted secondary span switches remap hits off
        rmp_span_ok = (sec_limit >= sec_base);
        // primary window is as wide as the secondary one; one that runs
        // past the top of the space wraps below pri_base and never hits
        rmp_limit   = pri_base + (sec_limit - sec_base);
        req_offset  = i_req.addr - pri_base;
    end

    // comparators for the opaque window and the primary remap window
    oar_span_check u_opq_span (
        .i_base  (opq_base),
        .i_limit (opq_limit),
        .i_addr  (i_req.addr),
        .o_hit   (opq_in_span)
    );

    oar_span_check u_rmp_span (
        .i_base  (pri_base),
        .i_limit (rmp_limit),
        .i_addr  (i_req.addr),
        .o_hit   (rmp_in_span)
    );

    // opaque takes priority over remap
    always_comb begin
        opq_hit = i_req.valid && i_req.is_mem && opaque_range_enable_reg && opq_in_span;
        rmp_hit = i_req.valid && !opq_hit && remap_enable_reg && rmp_span_ok && rmp_in_span;
    end

    always_comb begin
        // idle answers stay all zero so no stale address leaks downstream
        rsp_next           = '0;
        if (i_req.valid) begin
            rsp_next.valid = 1'b1;
            rsp_next.addr  = i_req.addr;
        end
        if (opq_hit) begin
            rsp_next.refuse_ur = i_req.from_primary;
            rsp_next.refuse_ma = !i_req.from_primary;
        end else if (rmp_hit) begin
            rsp_next.remapped = 1'b1;
            rsp_next.addr     = sec_base + req_offset;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rsp <= '0;
        end else begin
            o_rsp <= rsp_next;
        end
    end

    // hit counters; a hit in the clearing cycle is kept (the set wins)
    always_comb begin
        status_clear = wr_at(`OAR_OFS_STATUS);
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            opq_cnt_reg <= `OAR_RST_CNT;
        end else if (status_clear && opq_hit) begin
            opq_cnt_reg <= oar_sat_inc(`OAR_RST_CNT);
        end else if (status_clear) begin
            opq_cnt_reg <= `OAR_RST_CNT;
        end else if (opq_hit) begin
            opq_cnt_reg <= oar_sat_inc(opq_cnt_reg);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rmp_cnt_reg <= `OAR_RST_CNT;
        end else if (status_clear && rmp_hit) begin
            rmp_cnt_reg <= oar_sat_inc(`OAR_RST_CNT);
        end else if (status_clear) begin
            rmp_cnt_reg <= `OAR_RST_CNT;
        end else if (rmp_hit) begin
            rmp_cnt_reg <= oar_sat_inc(rmp_cnt_reg);
        end
    end

    // enables mirrored for the rest of the bridge, one cycle behind
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_opaque_range_enable <= `OAR_RST_BIT;
        end else begin
            o_opaque_range_enable <= opaque_range_enable_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_remap_enable <= `OAR_RST_BIT;
        end else begin
            o_remap_enable <= remap_enable_reg;
        end
    end

endmodule

`default_nettype wire

/* File: oar_defines.svh */
/*
 * register offsets, field positions and reset values of the opaque and
 * remap window registers.
 * assumes an 8-bit word-aligned register address from the owning block.
 */
`ifndef OAR_DEFINES_SVH
`define OAR_DEFINES_SVH

`define OAR_REG_AW        8
`define OAR_OFS_OPQ_CTRL  8'h58
`define OAR_OFS_OPQ_LOW   8'h5c
`define OAR_OFS_OPQ_BHI   8'h60
`define OAR_OFS_OPQ_LHI   8'h64
`define OAR_OFS_RMP_CTRL  8'h68
`define OAR_OFS_PRI_BHI   8'h6c
`define OAR_OFS_SEC_BLO   8'h70
`define OAR_OFS_SEC_BHI   8'h74
`define OAR_OFS_SEC_LLO   8'h78
`define OAR_OFS_SEC_LHI   8'h7c
`define OAR_OFS_STATUS    8'hf0

`define OAR_OPQ_EN_BIT    5
`define OAR_RMP_EN_BIT    3
`define OAR_LO_MSB        31
`define OAR_LO_LSB        20
`define OAR_LB_MSB        15
`define OAR_LB_LSB        4
`define OAR_LL64_MSB      19
`define OAR_LL64_LSB      16
`define OAR_LB64_MSB      3
`define OAR_LB64_LSB      0
`define OAR_ADDR64_CODE   4'h1

`define OAR_RST_WORD      32'h0000_0000
`define OAR_RST_FIELD     12'h000
`define OAR_RST_BIT       1'b0
`define OAR_RST_CNT       16'h0000

`endif

/* File: oar_pkg.sv */
/*
 * types and shared helpers of the opaque and remap decoder.
 * assumes oar_defines.svh sits in the include path.
 */
package oar_pkg;

    typedef logic [63:0] oar_addr_t;

    typedef struct packed {
        logic      valid;
        logic      is_mem;
        logic      from_primary;
        oar_addr_t addr;
    } oar_req_s;

    typedef struct packed {
        logic      valid;
        logic      refuse_ur;
        logic      refuse_ma;
        logic      remapped;
        oar_addr_t addr;
    } oar_rsp_s;

    // base: low bits taken as zeros
    function automatic oar_addr_t oar_base64(input logic [31:0] hi, input logic [11:0] lo);
        oar_base64 = {hi, lo, 20'h00000};
    endfunction

    // limit: low bits taken as ones
    function automatic oar_addr_t oar_limit64(input logic [31:0] hi, input logic [11:0] lo);
        oar_limit64 = {hi, lo, 20'hfffff};
    endfunction

    function automatic logic [15:0] oar_sat_inc(input logic [15:0] v);
        oar_sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

endpackage

/* File: oar_span_check.sv */
/*
 * inclusive base-to-limit window comparator.
 * assumes base and limit are already widened to 64 bits.
 */
`timescale 1ns/1ps
`default_nettype none

module oar_span_check
    import oar_pkg::*;
(
    // window
    input  wire oar_addr_t i_base,
    input  wire oar_addr_t i_limit,
    // probe
    input  wire oar_addr_t i_addr,
    output logic           o_hit
);

    always_comb begin
        o_hit = (i_addr >= i_base) && (i_addr <= i_limit);
    end

endmodule

`default_nettype wire

/* File: oar_remap_asserts.sv */
/* port checker for oar_remap.
   assumes a bind to oar_remap and its single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module oar_remap_asserts
    import oar_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rd_data,
    input wire oar_req_s    i_req,
    input wire oar_rsp_s    o_rsp,
    input wire logic        o_opaque_range_enable,
    input wire logic        o_remap_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_rsp_lat; i_req.valid |=> o_rsp.valid; endproperty
    a_rsp_lat: assert property (p_rsp_lat) else $error("no answer after request");
    property p_rsp_idle; !i_req.valid |=> !o_rsp.valid; endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer without request");
    property p_ctrl_rsvd; i_rd && i_addr == 8'h68 |=> o_rd_data[19:4] == 16'h0000 && o_rd_data[2:0] == 3'h0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits set");
    property p_sec_rsvd; i_rd && (i_addr == 8'h70 || i_addr == 8'h78) |=> o_rd_data[19:0] == 20'h00000;
    endproperty
    a_sec_rsvd: assert property (p_sec_rsvd) else $error("secondary reserved bits set");
    property p_rmp_en; i_wr && i_addr == 8'h68 |=> ##1 o_remap_enable == $past(i_wr_data[3], 2); endproperty
    a_rmp_en: assert property (p_rmp_en) else $error("remap enable not following write");
    property p_opq_en; i_wr && i_addr == 8'h58 |=> ##1 o_opaque_range_enable == $past(i_wr_data[5], 2);
    endproperty
    a_opq_en: assert property (p_opq_en) else $error("opaque enable not following write");
    property p_mem_only; i_req.valid && !i_req.is_mem |=> !o_rsp.refuse_ur && !o_rsp.refuse_ma; endproperty
    a_mem_only: assert property (p_mem_only) else $error("non-memory request refused");
    property p_refuse_dir;
        i_req.valid |=> (o_rsp.refuse_ur == ($past(i_req.from_primary) && (o_rsp.refuse_ur || o_rsp.refuse_ma)))
            && !(o_rsp.refuse_ur && o_rsp.refuse_ma);
    endproperty
    a_refuse_dir: assert property (p_refuse_dir) else $error("refusal kind wrong for side");
    property p_pass_addr; o_rsp.valid && !o_rsp.remapped |-> o_rsp.addr == $past(i_req.addr); endproperty
    a_pass_addr: assert property (p_pass_addr) else $error("untranslated address changed");

    c_ur: cover property (o_rsp.valid && o_rsp.refuse_ur);
    c_ma: cover property (o_rsp.valid && o_rsp.refuse_ma);
    c_rm: cover property (o_rsp.valid && o_rsp.remapped);
endmodule
`default_nettype wire

/* File: oar_link_model.sv */
/* request source standing for the link and the secondary bus.
   assumes the same clock as oar_remap; one request per issue call. */
`timescale 1ns/1ps
`default_nettype none
module oar_link_model
    import oar_pkg::*;
(
    input  wire logic i_clk,
    output var  oar_req_s o_req
);
    initial o_req = '0;
    // released fields show the inverse so stale values never match
    task automatic issue(input oar_addr_t a, input logic mem, input logic pri);
        @(posedge i_clk);
        o_req <= '{1'b1, mem, pri, a};
        @(posedge i_clk);
        o_req <= '{1'b0, ~mem, ~pri, ~a};
    endtask
endmodule
`default_nettype wire

/* File: test_oar_remap.sv */
/* self-checking bench of oar_remap: register access and window decode.
   assumes oar_link_model and oar_remap_asserts are compiled beside it. */
`timescale 1ns/1ps
`default_nettype none
module test_oar_remap
    import oar_pkg::*;
;
    logic        i_clk;
    logic        i_resetn;
    logic [7:0]  i_addr;
    logic [31:0] i_wr_data;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rd_data;
    oar_req_s    i_req;
    oar_rsp_s    o_rsp;
    logic        o_opq_en;
    logic        o_rmp_en;
    int          n_fail;
    int          n_compared;
    logic [7:0]  ofs [8] = '{8'h60, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h74, 8'h78, 8'h7c};
    logic [31:0] msk [8] = '{32'hffffffff, 32'hffffffff, 32'hfff00008, 32'hffffffff,
                             32'hfff00000, 32'hffffffff, 32'hfff00000, 32'hffffffff};

    oar_remap i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_req(i_req), .o_rsp(o_rsp),
        .o_opaque_range_enable(o_opq_en), .o_remap_enable(o_rmp_en));
    oar_link_model i_link (.i_clk(i_clk), .o_req(i_req));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check("read data", {32'h0, o_rd_data}, {32'h0, exp});
    endtask

    // kind is {memory, from primary}; flags are {unsupported, abort, remapped}
    task automatic req(input oar_addr_t a, input logic [1:0] kind, input logic [2:0] f, input oar_addr_t ea);
        i_link.issue(a, kind[1], kind[0]);
        @(negedge i_clk);
        check("answer flags", {60'h0, o_rsp.valid, o_rsp.refuse_ur, o_rsp.refuse_ma, o_rsp.remapped},
              {60'h0, 1'b1, f});
        check("answer address", o_rsp.addr, ea);
    endtask

    initial begin
        i_resetn = 1'b0;
        i_addr = 8'h00;
        i_wr_data = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int k = 0; k < 8; k++) rdc(ofs[k], 32'h0);
        rdc(8'h5c, 32'h00010001);
        check("enables after reset", {62'h0, o_opq_en, o_rmp_en}, 64'h0);
        for (int k = 0; k < 8; k++) begin
            wr(ofs[k], 32'hffffffff);
            rdc(ofs[k], msk[k]);
            wr(ofs[k], 32'ha5a5a5a5);
            rdc(ofs[k], msk[k] & 32'ha5a5a5a5);
        end
        wr(8'h80, 32'hffffffff);
        rdc(8'h80, 32'h0);
        // remap window: primary 1_0010_0000, secondary 2_0030_0000 to 2_004f_ffff
        wr(8'h6c, 32'h1);
        wr(8'h68, 32'h00100008);
        wr(8'h74, 32'h2);
        wr(8'h70, 32'h00300000);
        wr(8'h7c, 32'h2);
        wr(8'h78, 32'h00400000);
        check("remap enable", {63'h0, o_rmp_en}, 64'h1);
        req(64'h1_0012_3456, 2'b11, 3'b001, 64'h2_0032_3456);
        req(64'h1_002f_ffff, 2'b01, 3'b001, 64'h2_004f_ffff);
        req(64'h1_0030_0000, 2'b11, 3'b000, 64'h1_0030_0000);
        req(64'h1_000f_ffff, 2'b11, 3'b000, 64'h1_000f_ffff);
        // opaque range 1_0010_0000 to 1_002f_ffff over the remap window
        wr(8'h58, 32'h20);
        wr(8'h5c, 32'h00200010);
        wr(8'h60, 32'h1);
        wr(8'h64, 32'h1);
        rdc(8'h5c, 32'h00210011);
        check("opaque enable", {63'h0, o_opq_en}, 64'h1);
        req(64'h1_0012_3456, 2'b11, 3'b100, 64'h1_0012_3456);
        req(64'h1_002f_ffff, 2'b10, 3'b010, 64'h1_002f_ffff);
        req(64'h1_0012_3456, 2'b01, 3'b001, 64'h2_0032_3456);
        req(64'h1_0030_0000, 2'b10, 3'b000, 64'h1_0030_0000);
        // hit counters: three remap hits, two opaque hits so far
        rdc(8'hf0, 32'h0003_0002);
        // clear and an opaque hit in the same cycle leave a count of one
        fork
            wr(8'hf0, 32'h0);
            i_link.issue(64'h1_0012_3456, 1'b1, 1'b1);
        join
        rdc(8'hf0, 32'h0000_0001);
        wr(8'h58, 32'h0);
        wr(8'h68, 32'h00100000);
        req(64'h1_0012_3456, 2'b11, 3'b000, 64'h1_0012_3456);
        check("remap enable", {63'h0, o_rmp_en}, 64'h0);
        // reset in mid-run clears every field again
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int k = 0; k < 8; k++) rdc(ofs[k], 32'h0);
        rdc(8'h5c, 32'h00010001);
        rdc(8'hf0, 32'h0);
        check("enables after reset", {62'h0, o_opq_en, o_rmp_en}, 64'h0);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        report_and_stop();
    end
endmodule

bind oar_remap oar_remap_asserts i_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_req(i_req),
    .o_rsp(o_rsp), .o_opaque_range_enable(o_opaque_range_enable), .o_remap_enable(o_remap_enable));
`default_nettype wire
